/* include/mtl_pkg.sv */
// Purpose: shared constants and types of the multichannel timer link block
// Assumes: six channels of 16-bit counters, four compare slots per channel
// Notes:   slots C and D exist only on the two buffered channels
package mtl_pkg;
  localparam int NCH       = 6;
  localparam int NREG      = 4;
  localparam int NREG_BASE = 2;
  localparam int CW        = 16;
  localparam int PS_W      = 6;
  localparam int NCLK_PIN  = 4;

  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CW-1:0] CNT_MAX  = 16'hffff;
  localparam logic [CW-1:0] CNT_ONE  = 16'h0001;

  // channel roles
  localparam int BUF_CH_LO = 0;
  localparam int BUF_CH_HI = 3;
  localparam int CASC_UP0  = 1;
  localparam int CASC_LO0  = 2;
  localparam int CASC_UP1  = 4;
  localparam int CASC_LO1  = 5;
  localparam int PH_PAIR_AB = 0;
  localparam int PH_PAIR_CD = 1;

  // clock_source_sel codes
  localparam logic [2:0] CK_DIV1    = 3'h0;
  localparam logic [2:0] CK_DIV4    = 3'h1;
  localparam logic [2:0] CK_DIV16   = 3'h2;
  localparam logic [2:0] CK_DIV64   = 3'h3;
  localparam logic [2:0] CK_CASCADE = 3'h7;
  localparam logic [PS_W-1:0] PS_MASK_DIV1  = 6'h00;
  localparam logic [PS_W-1:0] PS_MASK_DIV4  = 6'h03;
  localparam logic [PS_W-1:0] PS_MASK_DIV16 = 6'h0f;
  localparam logic [PS_W-1:0] PS_MASK_DIV64 = 6'h3f;

  // clear_source_sel codes
  localparam logic [2:0] CLR_NONE  = 3'h0;
  localparam logic [2:0] CLR_A     = 3'h1;
  localparam logic [2:0] CLR_B     = 3'h2;
  localparam logic [2:0] CLR_SYNC  = 3'h3;
  localparam logic [2:0] CLR_C     = 3'h5;
  localparam logic [2:0] CLR_D     = 3'h6;
  localparam logic [2:0] CLR_SYNC2 = 3'h7;

  localparam logic [1:0] REG_A = 2'h0;
  localparam logic [1:0] REG_B = 2'h1;
  localparam logic [1:0] REG_C = 2'h2;
  localparam logic [1:0] REG_D = 2'h3;

  // out_action field: [3] capture, [2] initial level, [1:0] action or edge
  localparam int ACT_CAP_BIT  = 3;
  localparam int ACT_INIT_BIT = 2;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] EDGE_RISE  = 2'h0;
  localparam logic [1:0] EDGE_FALL  = 2'h1;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_PWM1   = 4'h2,
    MODE_PWM2   = 4'h4,
    MODE_PHASE  = 4'h8
  } mtl_mode_t;

  typedef struct packed {
    logic [2:0]                 clock_source_sel;
    logic [2:0]                 clear_source_sel;
    mtl_mode_t                  mode;
    logic [NREG_BASE-1:0]       buffer_en;
    logic [NREG-1:0][3:0]       out_action;
  } mtl_chan_cfg_t;

  typedef struct packed {
    logic          cnt_wr;
    logic          reg_wr;
    logic [2:0]    ch;
    logic [1:0]    sel;
    logic [CW-1:0] data;
  } mtl_sw_wr_t;
endpackage

/* logic/mtl_pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: pins are asynchronous to I_CLK_SYS
// Notes:   level moves only when stages two and three agree
`timescale 1ns/1ns
module mtl_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_prev
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_level <= '0;
      o_prev  <= '0;
    end else begin
      o_level <= (s2 & s3) | (o_level & (s2 ^ s3));
      o_prev  <= o_level;
    end
  end
endmodule // mtl_pin_sync

/* logic/mtl_phase_dec.sv */
// Purpose: two-phase encoder decode, count on every edge of either phase
// Assumes: inputs are filtered levels and their previous values
// Notes:   purely combinational
`timescale 1ns/1ns
module mtl_phase_dec (
  input  wire logic i_a,
  input  wire logic i_a_prev,
  input  wire logic i_b,
  input  wire logic i_b_prev,
  output logic      o_up,
  output logic      o_dn
);
  logic a_r;
  logic a_f;
  logic b_r;
  logic b_f;

  assign a_r  = i_a & ~i_a_prev;
  assign a_f  = ~i_a & i_a_prev;
  assign b_r  = i_b & ~i_b_prev;
  assign b_f  = ~i_b & i_b_prev;
  assign o_up = (a_r & ~i_b) | (a_f & i_b) | (b_r & i_a) | (b_f & ~i_a);
  assign o_dn = (a_r & i_b) | (a_f & ~i_b) | (b_r & ~i_a) | (b_f & i_a);
endmodule // mtl_phase_dec

/* logic/mtl_timer_link.sv */
// Purpose: six-channel timer with sync, buffer, cascade and PWM modes
// Assumes: software drives config ports and write strobes on I_CLK_SYS
// Notes:   pins and encoder clocks are synchronised inside
// Behaviour
// - writing a synced counter loads the value into all synced counters
// - a synced channel's clear event clears all synced sync-clear counters
// - all six channels may take part in synchronous operation
// - only channels 0 and 3 buffer: C buffers A, D buffers B
// - buffered compare match copies buffer into general register
// - buffered capture stores counter, old value moves to buffer
// - buffered PWM: A match changes pin and reloads A together
// - channels 1/2 and 4/5 cascade into 32-bit counters, upper first
// - cascaded upper counts up on lower overflow, down on underflow
// - lower underflow only exists in phase counting mode
// - upper in phase mode ignores cascade select, counts its encoder
// - in PWM a compare match drives pin low, high or toggles it
// - PWM per channel, with sync; clear by match sets the period
// - PWM1 pairs A/B and C/D, only A and C pins output
// - PWM1 initial level comes from the A or C setting
// - PWM1 equal pair values leave the pin unchanged on match
// - PWM1 gives up to eight outputs across the unit
// - PWM2 one register is period, others duty each on own pin
// - PWM2 period clear returns every pin to its initial level
// - PWM2 duty equal to period leaves pin unchanged on match
// - PWM2 with sync gives up to fifteen outputs
// - PWM2 period register's pin gives no output
// - only channels with their sync select bit set are synchronised
// - a counter counts only while its run bit is one
// - three-bit clear source selects match, capture or sync clearing
`timescale 1ns/1ns
module mtl_timer_link #(
  parameter int NCH  = mtl_pkg::NCH,
  parameter int NREG = mtl_pkg::NREG,
  parameter int CW   = mtl_pkg::CW
) (
  input  wire logic                                I_CLK_SYS,
  input  wire logic                                I_NRST,
  input  wire logic [NCH-1:0]                      I_CHANNEL_RUN,
  input  wire logic [NCH-1:0]                      I_SYNC_SELECT,
  input  wire mtl_pkg::mtl_chan_cfg_t [NCH-1:0]    I_TIMER_CONTROL,
  input  wire mtl_pkg::mtl_sw_wr_t                 I_SW_WRITE,
  input  wire logic [NCH*NREG-1:0]                 I_WAVE_PIN,
  input  wire logic [mtl_pkg::NCLK_PIN-1:0]        I_CLK_PIN,
  output logic      [NCH*NREG-1:0]                 O_WAVE_PIN,
  output logic      [NCH*NREG-1:0]                 O_WAVE_PIN_OE_N,
  output logic      [NCH*NREG-1:0]                 O_EVENT,
  output logic      [NCH-1:0]                      O_COUNT_DOWN,
  output logic      [NCH-1:0][CW-1:0]              O_CHANNEL_COUNTER,
  output logic      [NCH-1:0][NREG-1:0][CW-1:0]    O_GENERAL_REG
);
  logic [NCH-1:0][CW-1:0]            cnt;
  logic [NCH-1:0][CW-1:0]            next_cnt;
  logic [NCH-1:0][NREG-1:0][CW-1:0]  gr;
  logic [NCH-1:0][NREG-1:0][CW-1:0]  next_gr;
  logic [NCH-1:0]                    fresh;
  logic [mtl_pkg::PS_W-1:0]          presc;
  logic [NCH*NREG-1:0]               wave_lvl;
  logic [NCH*NREG-1:0]               wave_prev;
  logic [mtl_pkg::NCLK_PIN-1:0]      ck_lvl;
  logic [mtl_pkg::NCLK_PIN-1:0]      ck_prev;
  logic [1:0]                        ph_up;
  logic [1:0]                        ph_dn;
  logic [NCH-1:0]                    base_up;
  logic [NCH-1:0]                    base_dn;
  logic [NCH-1:0]                    ovf_lo;
  logic [NCH-1:0]                    unf_lo;
  logic [NCH-1:0]                    up;
  logic [NCH-1:0]                    dn;
  logic [NCH-1:0][NREG-1:0]          matchv;
  logic [NCH-1:0][NREG-1:0]          capv;
  logic [NCH-1:0]                    hit;
  logic [NCH-1:0]                    clr;
  logic [NCH-1:0]                    load;
  logic                              sync_clr;
  logic                              sync_per_ok;
  logic [CW-1:0]                     sync_per_val;
  logic [NCH*NREG-1:0]               next_pin;
  logic [NCH*NREG-1:0]               next_oe_n;

  function automatic logic reg_exists(input int c, input int r);
    return (r < mtl_pkg::NREG_BASE) || (c == mtl_pkg::BUF_CH_LO) ||
           (c == mtl_pkg::BUF_CH_HI);
  endfunction

  function automatic logic phase_ok(input int c);
    return (c == mtl_pkg::CASC_UP0) || (c == mtl_pkg::CASC_LO0) ||
           (c == mtl_pkg::CASC_UP1) || (c == mtl_pkg::CASC_LO1);
  endfunction

  function automatic logic [mtl_pkg::PS_W-1:0] ps_mask(input logic [2:0] s);
    case (s)
      mtl_pkg::CK_DIV4:  return mtl_pkg::PS_MASK_DIV4;
      mtl_pkg::CK_DIV16: return mtl_pkg::PS_MASK_DIV16;
      mtl_pkg::CK_DIV64: return mtl_pkg::PS_MASK_DIV64;
      default:           return mtl_pkg::PS_MASK_DIV1;
    endcase
  endfunction

  function automatic logic clr_is_match(input logic [2:0] s);
    return (s == mtl_pkg::CLR_A) || (s == mtl_pkg::CLR_B) ||
           (s == mtl_pkg::CLR_C) || (s == mtl_pkg::CLR_D);
  endfunction

  function automatic logic clr_is_sync(input logic [2:0] s);
    return (s == mtl_pkg::CLR_SYNC) || (s == mtl_pkg::CLR_SYNC2);
  endfunction

  function automatic logic [1:0] clr_reg(input logic [2:0] s);
    case (s)
      mtl_pkg::CLR_A: return mtl_pkg::REG_A;
      mtl_pkg::CLR_B: return mtl_pkg::REG_B;
      mtl_pkg::CLR_C: return mtl_pkg::REG_C;
      default:        return mtl_pkg::REG_D;
    endcase
  endfunction

  function automatic logic apply_act(input logic lvl, input logic [1:0] a);
    case (a)
      mtl_pkg::ACT_LOW:    return 1'b0;
      mtl_pkg::ACT_HIGH:   return 1'b1;
      mtl_pkg::ACT_TOGGLE: return ~lvl;
      default:             return lvl;
    endcase
  endfunction

  mtl_pin_sync #(
    .W (NCH*NREG)
  ) u_wave_sync (
    .i_clk   (I_CLK_SYS),
    .i_nrst  (I_NRST),
    .i_pin   (I_WAVE_PIN),
    .o_level (wave_lvl),
    .o_prev  (wave_prev)
  );

  mtl_pin_sync #(
    .W (mtl_pkg::NCLK_PIN)
  ) u_clk_sync (
    .i_clk   (I_CLK_SYS),
    .i_nrst  (I_NRST),
    .i_pin   (I_CLK_PIN),
    .o_level (ck_lvl),
    .o_prev  (ck_prev)
  );

  // encoder pairs: pins A/B and C/D
  for (genvar k = 0; k < 2; k++) begin : g_phase
    mtl_phase_dec u_dec (
      .i_a      (ck_lvl[2*k]),
      .i_a_prev (ck_prev[2*k]),
      .i_b      (ck_lvl[2*k+1]),
      .i_b_prev (ck_prev[2*k+1]),
      .o_up     (ph_up[k]),
      .o_dn     (ph_dn[k])
    );
  end

  // count sources per channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      base_up[c] = I_CHANNEL_RUN[c] &
        (&(presc | ~ps_mask(I_TIMER_CONTROL[c].clock_source_sel)));
      base_dn[c] = 1'b0;
      if (phase_ok(c) &&
          I_TIMER_CONTROL[c].mode == mtl_pkg::MODE_PHASE) begin
        if (c == mtl_pkg::CASC_UP0 || c == mtl_pkg::CASC_LO1) begin
          base_up[c] = I_CHANNEL_RUN[c] & ph_up[mtl_pkg::PH_PAIR_AB];
          base_dn[c] = I_CHANNEL_RUN[c] & ph_dn[mtl_pkg::PH_PAIR_AB];
        end else begin
          base_up[c] = I_CHANNEL_RUN[c] & ph_up[mtl_pkg::PH_PAIR_CD];
          base_dn[c] = I_CHANNEL_RUN[c] & ph_dn[mtl_pkg::PH_PAIR_CD];
        end
      end
      ovf_lo[c] = base_up[c] & (cnt[c] == mtl_pkg::CNT_MAX);
      unf_lo[c] = base_dn[c] & (cnt[c] == mtl_pkg::CNT_ZERO);
    end
    for (int c = 0; c < NCH; c++) begin
      up[c] = base_up[c];
      dn[c] = base_dn[c];
      if ((c == mtl_pkg::CASC_UP0 || c == mtl_pkg::CASC_UP1) &&
          I_TIMER_CONTROL[c].clock_source_sel == mtl_pkg::CK_CASCADE &&
          I_TIMER_CONTROL[c].mode != mtl_pkg::MODE_PHASE) begin
        up[c] = I_CHANNEL_RUN[c] & ovf_lo[(c+1)%NCH];
        dn[c] = I_CHANNEL_RUN[c] & unf_lo[(c+1)%NCH];
      end
    end
  end

  // compare, capture, clear and preset events
  always_comb begin
    sync_clr = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      for (int r = 0; r < NREG; r++) begin
        matchv[c][r] = reg_exists(c, r) & I_CHANNEL_RUN[c] & fresh[c] &
          ~I_TIMER_CONTROL[c].out_action[r][mtl_pkg::ACT_CAP_BIT] &
          (cnt[c] == gr[c][r]);
        unique case (I_TIMER_CONTROL[c].out_action[r][1:0])
          mtl_pkg::EDGE_RISE:
            capv[c][r] = wave_lvl[c*NREG+r] & ~wave_prev[c*NREG+r];
          mtl_pkg::EDGE_FALL:
            capv[c][r] = ~wave_lvl[c*NREG+r] & wave_prev[c*NREG+r];
          default:
            capv[c][r] = wave_lvl[c*NREG+r] ^ wave_prev[c*NREG+r];
        endcase
        capv[c][r] = capv[c][r] & reg_exists(c, r) &
          I_TIMER_CONTROL[c].out_action[r][mtl_pkg::ACT_CAP_BIT];
      end
      hit[c] = 1'b0;
      if (clr_is_match(I_TIMER_CONTROL[c].clear_source_sel)) begin
        hit[c] = matchv[c][clr_reg(I_TIMER_CONTROL[c].clear_source_sel)] |
                 capv[c][clr_reg(I_TIMER_CONTROL[c].clear_source_sel)];
      end
      sync_clr = sync_clr | (I_SYNC_SELECT[c] & hit[c]);
    end
    for (int c = 0; c < NCH; c++) begin
      clr[c] = hit[c] | (I_SYNC_SELECT[c] & sync_clr &
        clr_is_sync(I_TIMER_CONTROL[c].clear_source_sel));
      load[c] = I_SW_WRITE.cnt_wr && (int'(I_SW_WRITE.ch) < NCH) &&
        ((int'(I_SW_WRITE.ch) == c) ||
         (I_SYNC_SELECT[c] && I_SYNC_SELECT[I_SW_WRITE.ch]));
    end
  end

  // counter next values: preset beats clear beats count
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (load[c]) begin
        next_cnt[c] = I_SW_WRITE.data;
      end else if (clr[c]) begin
        next_cnt[c] = mtl_pkg::CNT_ZERO;
      end else if (up[c]) begin
        next_cnt[c] = cnt[c] + mtl_pkg::CNT_ONE;
      end else if (dn[c]) begin
        next_cnt[c] = cnt[c] - mtl_pkg::CNT_ONE;
      end else begin
        next_cnt[c] = cnt[c];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      cnt   <= '0;
      fresh <= '0;
      presc <= '0;
    end else begin
      cnt   <= next_cnt;
      fresh <= load | clr | up | dn;
      presc <= presc + 6'h01;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_COUNT_DOWN <= '0;
    end else begin
      O_COUNT_DOWN <= (O_COUNT_DOWN & ~up) | dn;
    end
  end

  // general registers: hardware transfers win over software writes
  always_comb begin
    next_gr = gr;
    if (I_SW_WRITE.reg_wr && int'(I_SW_WRITE.ch) < NCH) begin
      next_gr[I_SW_WRITE.ch][I_SW_WRITE.sel] = I_SW_WRITE.data;
    end
    for (int c = 0; c < NCH; c++) begin
      for (int r = 0; r < NREG; r++) begin
        if (capv[c][r]) begin
          next_gr[c][r] = cnt[c];
        end
      end
      if (c == mtl_pkg::BUF_CH_LO || c == mtl_pkg::BUF_CH_HI) begin
        for (int r = 0; r < mtl_pkg::NREG_BASE; r++) begin
          if (I_TIMER_CONTROL[c].buffer_en[r]) begin
            if (capv[c][r]) begin
              next_gr[c][r+mtl_pkg::NREG_BASE] = gr[c][r];
            end else if (matchv[c][r]) begin
              next_gr[c][r] = gr[c][r+mtl_pkg::NREG_BASE];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      gr <= '0;
    end else begin
      gr <= next_gr;
    end
  end

  // period seen by sync-cleared channels: lowest synced match source
  always_comb begin
    sync_per_ok  = 1'b0;
    sync_per_val = mtl_pkg::CNT_ZERO;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (I_SYNC_SELECT[c] &&
          clr_is_match(I_TIMER_CONTROL[c].clear_source_sel)) begin
        sync_per_ok  = 1'b1;
        sync_per_val = gr[c][clr_reg(I_TIMER_CONTROL[c].clear_source_sel)];
      end
    end
  end

  // wave pin levels and enables
  always_comb begin
    logic [2:0]    sel;
    logic          own;
    logic          known;
    logic [CW-1:0] per;
    logic [3:0]    act;
    int            i;
    int            g;
    sel   = 3'h0;
    own   = 1'b0;
    known = 1'b0;
    per   = mtl_pkg::CNT_ZERO;
    act   = 4'h0;
    i     = 0;
    g     = 0;
    for (int c = 0; c < NCH; c++) begin
      sel   = I_TIMER_CONTROL[c].clear_source_sel;
      own   = clr_is_match(sel);
      known = own | (I_SYNC_SELECT[c] & clr_is_sync(sel) & sync_per_ok);
      per   = own ? gr[c][clr_reg(sel)] : sync_per_val;
      for (int p = 0; p < NREG; p++) begin
        i   = c * NREG + p;
        g   = (I_TIMER_CONTROL[c].mode == mtl_pkg::MODE_PWM1) ?
              (p / 2) * 2 : p;
        act = I_TIMER_CONTROL[c].out_action[p];
        next_pin[i]  = O_WAVE_PIN[i];
        next_oe_n[i] = 1'b1;
        if (!I_CHANNEL_RUN[c]) begin
          next_pin[i] = I_TIMER_CONTROL[c].out_action[g]
                          [mtl_pkg::ACT_INIT_BIT];
        end else begin
          unique case (I_TIMER_CONTROL[c].mode)
            mtl_pkg::MODE_PWM1: begin
              if (p % 2 == 0) begin
                if (matchv[c][p] && gr[c][p] != gr[c][p+1]) begin
                  next_pin[i] = apply_act(O_WAVE_PIN[i], act[1:0]);
                end else if (matchv[c][p+1] &&
                             gr[c][p] != gr[c][p+1]) begin
                  next_pin[i] = apply_act(O_WAVE_PIN[i],
                    I_TIMER_CONTROL[c].out_action[p+1][1:0]);
                end
              end
            end
            mtl_pkg::MODE_PWM2: begin
              if (clr[c]) begin
                next_pin[i] = act[mtl_pkg::ACT_INIT_BIT];
              end else if (matchv[c][p] &&
                           !(known && gr[c][p] == per)) begin
                next_pin[i] = apply_act(O_WAVE_PIN[i], act[1:0]);
              end
            end
            default: begin
              if (matchv[c][p]) begin
                next_pin[i] = apply_act(O_WAVE_PIN[i], act[1:0]);
              end
            end
          endcase
        end
        if (reg_exists(c, p) && !act[mtl_pkg::ACT_CAP_BIT]) begin
          unique case (I_TIMER_CONTROL[c].mode)
            mtl_pkg::MODE_PWM1:
              next_oe_n[i] = (p % 2 != 0);
            mtl_pkg::MODE_PWM2:
              next_oe_n[i] = own && (2'(p) == clr_reg(sel));
            default:
              next_oe_n[i] = (act[1:0] == mtl_pkg::ACT_NONE);
          endcase
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WAVE_PIN      <= '0;
      O_WAVE_PIN_OE_N <= '1;
    end else begin
      O_WAVE_PIN      <= next_pin;
      O_WAVE_PIN_OE_N <= next_oe_n;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_EVENT <= '0;
    end else begin
      O_EVENT <= matchv | capv;
    end
  end

  assign O_CHANNEL_COUNTER = cnt;
  assign O_GENERAL_REG     = gr;
endmodule // mtl_timer_link

/* bench/mtl_link_properties.sv */
// Purpose: port checks for the timer link
// Assumes: configuration is steady around checked events
// Notes:   helper flops hold last-cycle conditions
`timescale 1ns/1ns
module mtl_link_chk #(
  parameter int NCH  = mtl_pkg::NCH,
  parameter int NREG = mtl_pkg::NREG,
  parameter int CW   = mtl_pkg::CW
) (
  input wire logic                             I_CLK_SYS,
  input wire logic                             I_NRST,
  input wire logic [NCH-1:0]                   I_CHANNEL_RUN,
  input wire logic [NCH-1:0]                   I_SYNC_SELECT,
  input wire mtl_pkg::mtl_chan_cfg_t [NCH-1:0] I_TIMER_CONTROL,
  input wire mtl_pkg::mtl_sw_wr_t              I_SW_WRITE,
  input wire logic [NCH*NREG-1:0]              O_WAVE_PIN,
  input wire logic [NCH*NREG-1:0]              O_WAVE_PIN_OE_N,
  input wire logic [NCH*NREG-1:0]              O_EVENT,
  input wire logic [NCH-1:0][CW-1:0]           O_CHANNEL_COUNTER,
  input wire logic [NCH-1:0][NREG-1:0][CW-1:0] O_GENERAL_REG
);
  logic clr0b;
  logic sclr1;
  logic buf0;
  logic casc1;
  assign casc1 = I_TIMER_CONTROL[1].clock_source_sel == mtl_pkg::CK_CASCADE
    && I_TIMER_CONTROL[1].mode == mtl_pkg::MODE_NORMAL
    && I_TIMER_CONTROL[1].clear_source_sel == mtl_pkg::CLR_NONE
    && I_TIMER_CONTROL[2].clear_source_sel == mtl_pkg::CLR_NONE
    && I_CHANNEL_RUN[1] && !I_SW_WRITE.cnt_wr;
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      clr0b <= 1'b0;
      sclr1 <= 1'b0;
      buf0  <= 1'b0;
    end else begin
      clr0b <= I_TIMER_CONTROL[0].clear_source_sel == mtl_pkg::CLR_B
        && !I_SW_WRITE.cnt_wr;
      sclr1 <= I_SYNC_SELECT[0] && I_SYNC_SELECT[1]
        && I_TIMER_CONTROL[1].clear_source_sel == mtl_pkg::CLR_SYNC;
      buf0  <= I_TIMER_CONTROL[0].buffer_en[0]
        && !I_TIMER_CONTROL[0].out_action[0][3];
    end
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  property p_preset;
    I_SW_WRITE.cnt_wr && I_SW_WRITE.ch == 3'h0 && I_SYNC_SELECT[0]
      && I_SYNC_SELECT[1] |=> O_CHANNEL_COUNTER[1] == $past(I_SW_WRITE.data);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset missed channel 1");
  property p_freeze;
    !I_CHANNEL_RUN[2] && I_TIMER_CONTROL[2].clear_source_sel == 3'h0
      && !(I_SW_WRITE.cnt_wr && (I_SW_WRITE.ch == 3'h2 || I_SYNC_SELECT[2]))
      |=> $stable(O_CHANNEL_COUNTER[2]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("stopped counter moved");
  property p_bd_off;
    (I_TIMER_CONTROL[0].mode == mtl_pkg::MODE_PWM1)[*2] |-> O_WAVE_PIN_OE_N[1];
  endproperty
  a_bd_off: assert property (p_bd_off)
    else $error("second pin driven in pwm1");
  property p_init;
    (!I_CHANNEL_RUN[0] && I_TIMER_CONTROL[0].mode == mtl_pkg::MODE_PWM1
      && !I_TIMER_CONTROL[0].out_action[0][3])[*2]
      ##0 $stable(I_TIMER_CONTROL[0].out_action[0])
      |-> O_WAVE_PIN[0] == I_TIMER_CONTROL[0].out_action[0][2];
  endproperty
  a_init: assert property (p_init)
    else $error("initial level wrong");
  property p_cascade;
    casc1 && O_CHANNEL_COUNTER[2] == 16'hffff ##1
      O_CHANNEL_COUNTER[2] == 16'h0000
      |-> O_CHANNEL_COUNTER[1] == $past(O_CHANNEL_COUNTER[1]) + 16'h0001;
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("upper half missed carry");
  property p_clear;
    O_EVENT[1] && clr0b |-> O_CHANNEL_COUNTER[0] == 16'h0000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("match did not clear");
  property p_sclr;
    O_EVENT[1] && clr0b && sclr1 |-> O_CHANNEL_COUNTER[1] == 16'h0000;
  endproperty
  a_sclr: assert property (p_sclr)
    else $error("synchronous clear missed");
  property p_reload;
    O_EVENT[0] && buf0 |-> O_GENERAL_REG[0][0] == $past(O_GENERAL_REG[0][2]);
  endproperty
  a_reload: assert property (p_reload)
    else $error("buffer not reloaded");
  c_wrap: cover property (casc1 && O_CHANNEL_COUNTER[2] == 16'h0000);
  c_sclr: cover property (O_EVENT[1] && clr0b && sclr1);
  c_reload: cover property (O_EVENT[0] && buf0);
endmodule // mtl_link_chk
bind mtl_timer_link mtl_link_chk #(.NCH(NCH), .NREG(NREG), .CW(CW))
  mtl_link_chk_inst (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST),
  .I_CHANNEL_RUN(I_CHANNEL_RUN), .I_SYNC_SELECT(I_SYNC_SELECT),
  .I_TIMER_CONTROL(I_TIMER_CONTROL), .I_SW_WRITE(I_SW_WRITE),
  .O_WAVE_PIN(O_WAVE_PIN), .O_WAVE_PIN_OE_N(O_WAVE_PIN_OE_N),
  .O_EVENT(O_EVENT), .O_CHANNEL_COUNTER(O_CHANNEL_COUNTER),
  .O_GENERAL_REG(O_GENERAL_REG));

/* bench/tb.sv */
// Purpose: directed bench for the timer link
// Assumes: inputs change at the falling edge
// Notes:   pin levels are read in event cycles
`timescale 1ns/1ns
module tb;
  logic                         clk;
  logic                         nrst;
  logic [5:0]                   run;
  logic [5:0]                   sync;
  mtl_pkg::mtl_chan_cfg_t [5:0] cfg;
  mtl_pkg::mtl_sw_wr_t          sw;
  logic [23:0]                  wpin;
  logic [23:0]                  pin;
  logic [23:0]                  oe_n;
  logic [23:0]                  ev;
  logic [5:0][15:0]             cnt;
  logic [5:0][3:0][15:0]        gr;
  logic [15:0]                  lat;
  logic [3:0]                   ckp;
  logic [5:0]                   cdn;
  int                           err_count;
  int                           n_checks;
  mtl_timer_link mtl_timer_link_inst (.I_CLK_SYS(clk), .I_NRST(nrst),
    .I_CHANNEL_RUN(run), .I_SYNC_SELECT(sync), .I_TIMER_CONTROL(cfg),
    .I_SW_WRITE(sw), .I_WAVE_PIN(wpin), .I_CLK_PIN(ckp), .O_WAVE_PIN(pin),
    .O_WAVE_PIN_OE_N(oe_n), .O_EVENT(ev), .O_COUNT_DOWN(cdn),
    .O_CHANNEL_COUNTER(cnt), .O_GENERAL_REG(gr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic c, input int ch, input logic [1:0] s,
    input logic [15:0] d);
    @(negedge clk);
    sw = '{c, !c, 3'(ch), s, d};
    @(negedge clk);
    sw = '0;
  endtask
  task automatic wev(input int i);
    @(negedge clk);
    for (int n = 0; n < 60 && ev[i] !== 1'b1; n++) @(negedge clk);
    chk(16'(ev[i]), 16'h0001);
  endtask
  task automatic summarize;
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    err_count++;
    summarize();
  end
  initial begin
    nrst = 1'b0; run = '0; sync = '0; sw = '0; wpin = '0;
    ckp = '0;
    for (int k = 0; k < 6; k++)
      cfg[k] = '{3'h0, 3'h0, mtl_pkg::MODE_NORMAL, 2'h0, 16'h0};
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    sync = 6'h3f;
    for (int k = 0; k < 6; k++) begin
      wr(1'b1, k, 2'h0, 16'h0100 + 16'(k));
      for (int j = 0; j < 6; j++) chk(cnt[j], 16'h0100 + 16'(k));
    end
    sync = 6'h2a;
    wr(1'b1, 1, 2'h0, 16'h0abc);
    for (int j = 0; j < 6; j++)
      chk(cnt[j], sync[j] ? 16'h0abc : 16'h0105);
    sync = '0;
    for (int u = 1; u < 5; u += 3) begin
      wr(1'b1, u, 2'h0, 16'h0007);
      wr(1'b1, u + 1, 2'h0, 16'hfffe);
      cfg[u].clock_source_sel = mtl_pkg::CK_CASCADE;
    end
    cfg[4].mode = mtl_pkg::MODE_PHASE;
    run = 6'h36;
    for (int n = 0; n < 20 && cnt[2] !== 16'h0000; n++) @(negedge clk);
    run = '0;
    chk(cnt[1], 16'h0008);
    chk(cnt[4], 16'h0007);
    cfg[1] = '{3'h0, mtl_pkg::CLR_SYNC, mtl_pkg::MODE_NORMAL, 2'h0, 16'h0};
    cfg[4].mode = mtl_pkg::MODE_NORMAL;
    // a: init high, low on match; b: high on match
    cfg[0] = '{3'h0, mtl_pkg::CLR_B, mtl_pkg::MODE_PWM1, 2'h1, 16'h0025};
    wr(1'b1, 0, 2'h0, 16'h0000);
    wr(1'b1, 1, 2'h0, 16'h0040);
    wr(1'b0, 0, mtl_pkg::REG_A, 16'h0003);
    wr(1'b0, 0, mtl_pkg::REG_B, 16'h0008);
    wr(1'b0, 0, mtl_pkg::REG_C, 16'h0005);
    chk(16'(pin[0]), 16'h0001);
    chk(16'(oe_n[1:0]), 16'h0002);
    sync = 6'h03;
    run = 6'h03;
    wev(0);
    lat = cnt[0] - 16'h0003;
    chk(16'(pin[0]), 16'h0000);
    chk(gr[0][0], 16'h0005);
    wev(1);
    chk(16'(pin[0]), 16'h0001);
    chk(cnt[0], 16'h0000);
    chk(cnt[1], 16'h0000);
    wev(0);
    chk(cnt[0], 16'h0005 + lat);
    run = '0;
    sync = '0;
    // period on a; b, c high on match; d init high, low on match
    cfg[3] = '{3'h0, mtl_pkg::CLR_A, mtl_pkg::MODE_PWM2, 2'h0, 16'h5223};
    wr(1'b1, 3, 2'h0, 16'h0000);
    wr(1'b0, 3, mtl_pkg::REG_A, 16'h000a);
    wr(1'b0, 3, mtl_pkg::REG_B, 16'h0004);
    wr(1'b0, 3, mtl_pkg::REG_C, 16'h000a);
    wr(1'b0, 3, mtl_pkg::REG_D, 16'h0006);
    run = 6'h08;
    wev(13);
    chk(16'(pin[15:13]), 16'h0005);
    wev(15);
    chk(16'(pin[15]), 16'h0000);
    wev(12);
    chk(16'(pin[15:12]), 16'h0008);
    chk(16'(oe_n[15:12]), 16'h0001);
    run = '0;
    cfg[0] = '{3'h0, 3'h0, mtl_pkg::MODE_NORMAL, 2'h1, 16'h0008};
    wr(1'b0, 0, mtl_pkg::REG_A, 16'h0aaa);
    wr(1'b1, 0, 2'h0, 16'h0321);
    wpin[0] = 1'b1;
    wev(0);
    chk(gr[0][0], 16'h0321);
    chk(gr[0][2], 16'h0aaa);
    // one encoder edge counts channel 5 down from zero, borrowing from 4
    cfg[5].mode = mtl_pkg::MODE_PHASE;
    run = 6'h30;
    ckp = 4'h2;
    repeat (8) @(negedge clk);
    chk(cnt[5], 16'hffff);
    chk(cnt[4], 16'h0006);
    chk(16'(cdn), 16'h0030);
    summarize();
  end
endmodule // tb
